// *** bert_checker.v ***
// sequence bit error checker with wishbone registers and interrupt
// Operation
// - stop at bit limit, cause bits
// - stop at error limit, cause errors
// - excluded bits never counted as checked
// - internal reference sequence compared per bit
// - auto inversion for 15 and 23 stage
// - normal polarity: high means one
// - inverted polarity: low means one
// - restart rise latches partial, halts measurement
// - restart fall resynchronises, starts next subinterval
// - counts accumulate across subintervals until limit
// - enabling gating or exclusion resets measurement
// - restart off: internal measurement reset
// - low-active gating suspends checker and generator
// - exclude runs of 32, generator keeps running
// - no sync before clock and data seen
`timescale 1ns/100ps
`include "bert_map.vh"
module bert_checker #(
  parameter CNT_W = 32
) (
  // clock, reset, enable
  input  wire              clk_i,
  input  wire              rst_i,
  input  wire              ce_i,
  // wishbone slave
  input  wire              wb_cyc_i,
  input  wire              wb_stb_i,
  input  wire              wb_we_i,
  input  wire [`ADR_W-1:0] wb_adr_i,
  input  wire [3:0]        wb_sel_i,
  input  wire [31:0]       wb_dat_i,
  output reg  [31:0]       wb_dat_o,
  output reg               wb_ack_o,
  // pins from the device under test
  input  wire              data_clk_i,
  input  wire              data_i,
  input  wire              restart_i,
  input  wire              data_enable_i,
  // status
  output reg               irq_o,
  output reg               sync_o,
  output reg               running_o,
  output reg  [1:0]        stop_cause_indicator_o
);
  // --------------------------------------------------------------------------
  // states
  // --------------------------------------------------------------------------
  localparam ST_IDLE   = 3'h0;
  localparam ST_FILL   = 3'h1;
  localparam ST_VERIFY = 3'h2;
  localparam ST_RUN    = 3'h3;
  localparam ST_HALT   = 3'h4;
  reg  [2:0]       state;
  reg  [10:0]      ctrl;
  reg  [CNT_W-1:0] max_bits;
  reg  [CNT_W-1:0] max_errors;
  reg  [CNT_W-1:0] bit_count;
  reg  [CNT_W-1:0] err_count;
  reg  [`IRQ_W-1:0] irq_stat;
  reg  [`IRQ_W-1:0] irq_en;
  reg  [4:0]       phase_cnt;
  reg              clk_seen;
  reg              data_seen;
  reg              prev_bit;
  reg  [3:0]       pins_d;
  wire [3:0]       pins_s;
  // --------------------------------------------------------------------------
  // pin synchronisation and edge detection
  // --------------------------------------------------------------------------
  pin_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   ({data_enable_i, restart_i, data_i, data_clk_i}),
    .q_o   (pins_s)
  );
  always @(posedge clk_i)
  begin
    if (rst_i)
      pins_d <= 4'h0;
    else if (ce_i)
      pins_d <= pins_s;
  end
  // data is taken on the rising data clock edge; the 200 MHz sampling adds
  // up to 5 ns of skew, so the source should change data near its falling edge
  wire clk_rise  = pins_s[0] & ~pins_d[0];
  wire rst_rise  = pins_s[2] & ~pins_d[2];
  wire rst_fall  = ~pins_s[2] & pins_d[2];
  wire rx_bit    = pins_s[1] ^ ctrl[`CTRL_INV];
  wire [1:0] den_mode = ctrl[`CTRL_DEN_HI:`CTRL_DEN_LO];
  wire [1:0] ign_mode = ctrl[`CTRL_IGN_HI:`CTRL_IGN_LO];
  wire [2:0] prbs_sel = ctrl[`CTRL_SEL_HI:`CTRL_SEL_LO];
  wire       gate_ok  = (den_mode == `DEN_OFF) |
                        ((den_mode == `DEN_HIGH) & pins_s[3]) |
                        ((den_mode == `DEN_LOW) & ~pins_s[3]);
  wire       active   = (state == ST_FILL) | (state == ST_VERIFY) | (state == ST_RUN);
  // --------------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------------
  wire        bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        bus_wr  = bus_req & wb_we_i;
  wire        wr_ctrl = bus_wr & (wb_adr_i == `REG_CTRL);
  wire [31:0] wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] ctrl_wr = ({21'h000000, ctrl} & ~wmask) | (wb_dat_i & wmask);
  wire start_cmd = wr_ctrl & ctrl_wr[`CTRL_START];
  wire stop_cmd  = wr_ctrl & ctrl_wr[`CTRL_STOP];
  wire act_cmd   = wr_ctrl &
                   (((den_mode == `DEN_OFF) &
                     (ctrl_wr[`CTRL_DEN_HI:`CTRL_DEN_LO] != `DEN_OFF)) |
                    ((ign_mode == `IGN_OFF) &
                     (ctrl_wr[`CTRL_IGN_HI:`CTRL_IGN_LO] != `IGN_OFF)));
  // any start, and switching gating or exclusion on outside idle, restarts from scratch
  wire meas_reset = start_cmd | (act_cmd & (state != ST_IDLE));
  wire halt_now   = ctrl[`CTRL_XRST] & rst_rise & active;
  wire flush      = meas_reset | halt_now | stop_cmd;
  // --------------------------------------------------------------------------
  // constant-run exclusion delay line
  // --------------------------------------------------------------------------
  // bits are held back 32 places so a run can be dropped as a whole
  reg  [31:0] hist;
  reg  [31:0] excl;
  reg  [31:0] vld;
  reg  [5:0]  run;
  wire        in_valid = clk_rise & gate_ok & active;
  wire        target   = (ign_mode == `IGN_ONES);
  wire [5:0]  next_run = (rx_bit != target) ? 6'h00 :
                         (run == `IGN_RUN) ? run : run + 6'h01;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hist <= 32'h00000000;
      excl <= 32'h00000000;
      vld  <= 32'h00000000;
      run  <= 6'h00;
    end
    else if (ce_i)
    begin
      if (flush)
      begin
        hist <= 32'h00000000;
        excl <= 32'h00000000;
        vld  <= 32'h00000000;
        run  <= 6'h00;
      end
      else if (in_valid && ign_mode != `IGN_OFF)
      begin
        hist <= {hist[30:0], rx_bit};
        vld  <= {vld[30:0], 1'b1};
        run  <= next_run;
        if (next_run == `IGN_RUN)
          excl <= 32'hFFFFFFFF;
        else
          excl <= {excl[30:0], 1'b0};
      end
    end
  end
  wire ign_on   = (ign_mode != `IGN_OFF);
  wire ev_valid = ign_on ? (in_valid & vld[31]) : in_valid;
  wire ev_bit   = ign_on ? hist[31] : rx_bit;
  wire ev_excl  = ign_on & excl[31];
  // --------------------------------------------------------------------------
  // reference generator
  // --------------------------------------------------------------------------
  wire       ref_bit;
  wire       ref_inv;
  wire [4:0] order;
  wire       gen_step = ev_valid & ~halt_now & ~flush;
  wire       gen_load = (state == ST_FILL);
  prbs_gen u_gen (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .step_i     (gen_step),
    .load_i     (gen_load),
    .load_bit_i (ev_bit ^ ref_inv),
    .sel_i      (prbs_sel),
    .ref_bit_o  (ref_bit),
    .invert_o   (ref_inv),
    .order_o    (order)
  );
  wire             expect_bit = ref_bit ^ ref_inv;
  wire             mismatch   = (ev_bit != expect_bit);
  wire             counted    = ev_valid & ~ev_excl & (state == ST_RUN);
  wire [CNT_W-1:0] next_bits  = bit_count + {{(CNT_W-1){1'b0}}, 1'b1};
  wire [CNT_W-1:0] next_errs  = err_count + {{(CNT_W-1){1'b0}}, mismatch};
  wire             phase_end  = (phase_cnt == order - 5'h01);
  // --------------------------------------------------------------------------
  // measurement control, counters and registers
  // --------------------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state                  <= ST_IDLE;
      ctrl                   <= 11'h000;
      max_bits               <= `MAX_BITS_RST;
      max_errors             <= `MAX_ERRORS_RST;
      bit_count              <= {CNT_W{1'b0}};
      err_count              <= {CNT_W{1'b0}};
      irq_stat               <= {`IRQ_W{1'b0}};
      irq_en                 <= {`IRQ_W{1'b0}};
      phase_cnt              <= 5'h00;
      clk_seen               <= 1'b0;
      data_seen              <= 1'b0;
      prev_bit               <= 1'b0;
      stop_cause_indicator_o <= `CAUSE_NONE;
    end
    else if (ce_i)
    begin
      // register writes; start and stop are strobes and never stored
      if (wr_ctrl)
        ctrl <= {ctrl_wr[10:2], 2'h0};
      if (bus_wr && wb_adr_i == `REG_MAX_BITS)
        max_bits <= (max_bits & wmask[CNT_W-1:0]) ^ max_bits ^
                    (wb_dat_i[CNT_W-1:0] & wmask[CNT_W-1:0]);
      if (bus_wr && wb_adr_i == `REG_MAX_ERRORS)
        max_errors <= (max_errors & wmask[CNT_W-1:0]) ^ max_errors ^
                      (wb_dat_i[CNT_W-1:0] & wmask[CNT_W-1:0]);
      if (bus_wr && wb_adr_i == `REG_IRQ_ENABLE && wb_sel_i[0])
        irq_en <= wb_dat_i[`IRQ_W-1:0];
      // clock and data activity watch
      if (clk_rise)
      begin
        clk_seen <= 1'b1;
        prev_bit <= rx_bit;
        if (rx_bit != prev_bit)
          data_seen <= 1'b1;
      end
      if (meas_reset || (act_cmd && state == ST_IDLE))
      begin
        bit_count              <= {CNT_W{1'b0}};
        err_count              <= {CNT_W{1'b0}};
        phase_cnt              <= 5'h00;
        clk_seen               <= 1'b0;
        data_seen              <= 1'b0;
        stop_cause_indicator_o <= `CAUSE_NONE;
        state                  <= meas_reset ? ST_FILL : ST_IDLE;
      end
      else if (stop_cmd && state != ST_IDLE)
      begin
        state                  <= ST_IDLE;
        stop_cause_indicator_o <= `CAUSE_USER;
      end
      else if (halt_now)
        state <= ST_HALT;
      else
      begin
        case (state)
          ST_HALT:
            if (rst_fall)
            begin
              phase_cnt <= 5'h00;
              state     <= ST_FILL;
            end
          ST_FILL:
            if (ev_valid)
            begin
              // a run being dropped cannot seed the generator
              if (ev_excl)
                phase_cnt <= 5'h00;
              else if (phase_end)
              begin
                phase_cnt <= 5'h00;
                state     <= ST_VERIFY;
              end
              else
                phase_cnt <= phase_cnt + 5'h01;
            end
          ST_VERIFY:
            if (ev_valid && !ev_excl)
            begin
              // an error while locking means a bad seed: fill again
              if (mismatch)
              begin
                phase_cnt <= 5'h00;
                state     <= ST_FILL;
              end
              else if (phase_end)
              begin
                if (clk_seen && data_seen)
                  state <= ST_RUN;
              end
              else
                phase_cnt <= phase_cnt + 5'h01;
            end
          ST_RUN:
            if (counted)
            begin
              bit_count <= next_bits;
              err_count <= next_errs;
              if (next_errs >= max_errors)
              begin
                state                  <= ST_IDLE;
                stop_cause_indicator_o <= `CAUSE_ERRORS;
              end
              else if (next_bits >= max_bits)
              begin
                state                  <= ST_IDLE;
                stop_cause_indicator_o <= `CAUSE_BITS;
              end
            end
          default:
            state <= ST_IDLE;
        endcase
      end
      // sticky events: a set in the cycle of a clear wins
      irq_stat <= (irq_stat &
                   ~((bus_wr && wb_adr_i == `REG_IRQ_CLEAR && wb_sel_i[0]) ?
                     wb_dat_i[`IRQ_W-1:0] : {`IRQ_W{1'b0}})) |
                  {halt_now,
                   (state == ST_VERIFY) & ev_valid & ~ev_excl & ~mismatch &
                     phase_end & clk_seen & data_seen,
                   (state == ST_RUN) & counted &
                     ((next_errs >= max_errors) | (next_bits >= max_bits))};
    end
  end
  // --------------------------------------------------------------------------
  // bus answer and status outputs
  // --------------------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h00000000;
      irq_o     <= 1'b0;
      sync_o    <= 1'b0;
      running_o <= 1'b0;
    end
    else if (ce_i)
    begin
      wb_ack_o  <= bus_req;
      irq_o     <= |(irq_stat & irq_en);
      sync_o    <= (state == ST_RUN);
      running_o <= (state != ST_IDLE);
      // unmapped and write-only addresses read as zero
      if (!bus_req || wb_we_i)
        wb_dat_o <= 32'h00000000;
      else if (wb_adr_i == `REG_CTRL)
        wb_dat_o <= {21'h000000, ctrl};
      else if (wb_adr_i == `REG_STATUS)
        wb_dat_o <= {25'h0000000, data_seen, clk_seen, state == ST_HALT,
                     stop_cause_indicator_o, state == ST_RUN, state != ST_IDLE};
      else if (wb_adr_i == `REG_MAX_BITS)
        wb_dat_o <= max_bits;
      else if (wb_adr_i == `REG_MAX_ERRORS)
        wb_dat_o <= max_errors;
      else if (wb_adr_i == `REG_BIT_COUNT)
        wb_dat_o <= bit_count;
      else if (wb_adr_i == `REG_ERR_COUNT)
        wb_dat_o <= err_count;
      else if (wb_adr_i == `REG_IRQ_STATUS)
        wb_dat_o <= {29'h00000000, irq_stat};
      else if (wb_adr_i == `REG_IRQ_ENABLE)
        wb_dat_o <= {29'h00000000, irq_en};
      else
        wb_dat_o <= 32'h00000000;
    end
  end
endmodule // bert_checker

// *** bert_checker_sva.sv ***
// port assertions for the sequence bit error checker
`timescale 1ns/100ps
`include "bert_map.vh"
module bert_checker_sva (
  // clock and reset
  input wire        clk_i,
  input wire        rst_i,
  input wire        ce_i,
  // bus and link pins
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  input wire [31:0] wb_dat_o,
  input wire        data_clk_i,
  // status
  input wire        irq_o,
  input wire        sync_o,
  input wire        running_o,
  input wire [1:0]  stop_cause_indicator_o
);
  reg [1:0] pipe;
  reg [5:0] edges;
  // ----------------------------------------------------------------------------
  // link edges seen one flop earlier than the design, so the count never lags
  // ----------------------------------------------------------------------------
  always @(posedge clk_i)
  begin
    pipe <= {pipe[0], data_clk_i};
    if (rst_i || !running_o)
      edges <= 6'h00;
    else if (pipe[0] && !pipe[1] && edges != 6'h3F)
      edges <= edges + 6'h01;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_next_cycle: assert property (s_req |=> s_answer)
    else $error("bus request not answered by a single ack");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data outside ack");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i && ce_i |=> !irq_o && !sync_o
    && !running_o && stop_cause_indicator_o == `CAUSE_NONE)
    else $error("outputs not cleared by reset");
  a_sync_in_run: assert property (sync_o |-> running_o)
    else $error("sync while not measuring");
  a_sync_after_fill: assert property ($rose(sync_o) |-> edges >= 6'h12)
    else $error("sync before fill and verify bits");
  a_stop_has_cause: assert property ($fell(running_o) |-> stop_cause_indicator_o != `CAUSE_NONE)
    else $error("stop without cause");
  a_cause_idle_stable: assert property (!running_o && !$past(running_o) && !wb_cyc_i
    && !$past(wb_cyc_i) |=> $stable(stop_cause_indicator_o))
    else $error("stop cause changed while idle");
endmodule // bert_checker_sva
bind bert_checker bert_checker_sva i_bert_checker_sva (.clk_i, .rst_i, .ce_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .wb_dat_o, .data_clk_i, .irq_o, .sync_o, .running_o,
  .stop_cause_indicator_o);

// *** bert_map.vh ***
// register map, field positions and codes of the sequence bit error checker
`ifndef BERT_MAP_VH
`define BERT_MAP_VH
// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define ADR_W            8
`define REG_CTRL         8'h00
`define REG_STATUS       8'h04
`define REG_MAX_BITS     8'h08
`define REG_MAX_ERRORS   8'h0C
`define REG_BIT_COUNT    8'h10
`define REG_ERR_COUNT    8'h14
`define REG_IRQ_STATUS   8'h18
`define REG_IRQ_ENABLE   8'h1C
`define REG_IRQ_CLEAR    8'h20
// ----------------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------------
`define CTRL_START       0
`define CTRL_STOP        1
`define CTRL_SEL_LO      2
`define CTRL_SEL_HI      4
`define CTRL_INV         5
`define CTRL_XRST        6
`define CTRL_DEN_LO      7
`define CTRL_DEN_HI      8
`define CTRL_IGN_LO      9
`define CTRL_IGN_HI      10
`define DEN_OFF          2'h0
`define DEN_HIGH         2'h1
`define DEN_LOW          2'h2
`define IGN_OFF          2'h0
`define IGN_ONES         2'h1
`define IGN_ZEROS        2'h2
// ----------------------------------------------------------------------------
// stop causes, interrupt bits, sequence selections
// ----------------------------------------------------------------------------
`define CAUSE_NONE       2'h0
`define CAUSE_USER       2'h1
`define CAUSE_BITS       2'h2
`define CAUSE_ERRORS     2'h3
`define IRQ_W            3
`define IRQ_DONE         0
`define IRQ_SYNC         1
`define IRQ_PART         2
`define PRBS_9           3'h0
`define PRBS_11          3'h1
`define PRBS_15          3'h2
`define PRBS_16          3'h3
`define PRBS_20          3'h4
`define PRBS_21          3'h5
`define PRBS_23          3'h6
`define LFSR_W           23
`define IGN_RUN          6'h20
`define MAX_BITS_RST     32'h00989680
`define MAX_ERRORS_RST   32'h000186A0
`endif

// *** dut_source.sv ***
// behavioural device under test: clocked sequence source and restart pin
`timescale 1ns/100ps
module dut_source (
  // pins towards the checker
  output reg data_clk_o,
  output reg data_o,
  output reg restart_o
);
  reg [31:0] hist = 32'hFFFFFFFF;
  reg [31:0] taps = 32'h00000110;
  reg        flip = 1'b0;
  initial
  begin
    data_clk_o = 1'b0;
    data_o = 1'b0;
    restart_o = 1'b0;
  end
  // mode 0 sequence, 1 frozen filler, 2 sequence runs on under forced ones
  task send(input int cnt, input int mode, input int bad_at, input int bad_n);
    reg b;
    int i;
    for (i = 0; i < cnt; i++)
    begin
      b = ^(hist & taps);
      if (mode != 1)
        hist = {hist[30:0], b};
      if (mode == 1)
        data_o = ~data_o;
      else if (mode == 2)
        data_o = 1'b1;
      else
        data_o = b ^ flip ^ (i >= bad_at && i < bad_at + bad_n);
      #62.5 data_clk_o = 1'b1;
      #62.5 data_clk_o = 1'b0;
    end
    // clock stands still; the line must not keep showing the last bit
    data_o = ~data_o;
  endtask
endmodule // dut_source

// *** pin_sync.v ***
// two-flop synchronisers for pins arriving from outside the clock domain
`timescale 1ns/100ps
module pin_sync #(
  parameter WIDTH = 4
) (
  // clock and reset
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             ce_i,
  // pins and synchronised levels
  input  wire [WIDTH-1:0] d_i,
  output wire [WIDTH-1:0] q_o
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      reg meta;
      reg stable;
      always @(posedge clk_i)
      begin
        if (rst_i)
        begin
          meta   <= 1'b0;
          stable <= 1'b0;
        end
        else if (ce_i)
        begin
          meta   <= d_i[i];
          stable <= meta;
        end
      end
      assign q_o[i] = stable;
    end
  endgenerate
endmodule // pin_sync

// *** prbs_gen.v ***
// reference sequence generator, loadable from received bits
`timescale 1ns/100ps
`include "bert_map.vh"
module prbs_gen (
  // clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       ce_i,
  // stepping
  input  wire       step_i,
  input  wire       load_i,
  input  wire       load_bit_i,
  input  wire [2:0] sel_i,
  // reference
  output reg        ref_bit_o,
  output reg        invert_o,
  output reg  [4:0] order_o
);
  reg [`LFSR_W-1:0] state;

  always @*
  begin
    invert_o = 1'b0;
    case (sel_i)
      `PRBS_11: begin ref_bit_o = state[10] ^ state[8];  order_o = 5'h0B; end
      `PRBS_15: begin ref_bit_o = state[14] ^ state[13]; order_o = 5'h0F; invert_o = 1'b1; end
      `PRBS_16: begin ref_bit_o = state[15] ^ state[13] ^ state[12] ^ state[10];
                      order_o = 5'h10; end
      `PRBS_20: begin ref_bit_o = state[19] ^ state[2];  order_o = 5'h14; end
      `PRBS_21: begin ref_bit_o = state[20] ^ state[18]; order_o = 5'h15; end
      `PRBS_23: begin ref_bit_o = state[22] ^ state[17]; order_o = 5'h17; invert_o = 1'b1; end
      default:  begin ref_bit_o = state[8] ^ state[4];   order_o = 5'h09; end
    endcase
  end

  // loading shifts received bits in so the register picks up the phase
  always @(posedge clk_i)
  begin
    if (rst_i)
      state <= {`LFSR_W{1'b1}};
    else if (ce_i && step_i)
      state <= {state[`LFSR_W-2:0], load_i ? load_bit_i : ref_bit_o};
  end
endmodule // prbs_gen

// *** tb.sv ***
// self-checking bench for the sequence bit error checker
`timescale 1ns/100ps
`include "bert_map.vh"
module tb;
  typedef struct {logic [2:0] sel; logic [31:0] taps; int n; logic pol;} row_t;
  localparam [31:0] P9 = 32'h00000110;
  reg        clk_i = 1'b0;
  reg        rst_i = 1'b1;
  reg        ce_i = 1'b1;
  reg        wb_cyc_i = 1'b0;
  reg        wb_stb_i = 1'b0;
  reg        wb_we_i = 1'b0;
  reg [7:0]  wb_adr_i = 8'h00;
  reg [3:0]  wb_sel_i = 4'hF;
  reg [31:0] wb_dat_i = 32'h00000000;
  reg        data_enable_i = 1'b0;
  wire [31:0] wb_dat_o;
  wire       wb_ack_o, data_clk_i, data_i, restart_i, irq_o, sync_o, running_o;
  wire [1:0] stop_cause_indicator_o;
  reg [31:0] rd;
  int        fails = 0;
  int        samples_checked = 0;
  row_t rows [9] = '{'{`PRBS_9, P9, 9, 1'h0}, '{`PRBS_11, 32'h00000500, 11, 1'h0},
    '{`PRBS_15, 32'h00006000, 15, 1'h0}, '{`PRBS_16, 32'h0000B400, 16, 1'h0},
    '{`PRBS_20, 32'h00080004, 20, 1'h0}, '{`PRBS_21, 32'h00140000, 21, 1'h0},
    '{`PRBS_23, 32'h00420000, 23, 1'h0}, '{`PRBS_9, P9, 9, 1'h1},
    '{`PRBS_15, 32'h00006000, 15, 1'h1}};
  always #2.5 clk_i = ~clk_i;
  bert_checker i_bert_checker (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .data_clk_i, .data_i,
    .restart_i, .data_enable_i, .irq_o, .sync_o, .running_o, .stop_cause_indicator_o);
  dut_source i_dut_source (.data_clk_o(data_clk_i), .data_o(data_i), .restart_o(restart_i));
  // ----------------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------------
  task complete_run;
    $display("mismatches %0d, checks %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    t = 0;
    do
    begin
      @(posedge clk_i);
      t++;
    end
    while (wb_ack_o !== 1'b1 && t < 50);
    rd = wb_dat_o;
    chk("bus ack", 32'h1, {31'h0, wb_ack_o});
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    wb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  task start(input logic [31:0] taps, input logic flip, input logic [31:0] ctrl);
    i_dut_source.taps = taps;
    i_dut_source.hist = 32'hFFFFFFFF;
    i_dut_source.flip = flip;
    wb(1'b1, `REG_CTRL, ctrl);
  endtask
  task bits(input int n, input int mode);
    i_dut_source.send(n, mode, 1000, 0);
    repeat (10) @(posedge clk_i);
  endtask
  task counts(input logic [31:0] b, input logic [31:0] e);
    rd_chk(`REG_BIT_COUNT, b, "bit count");
    rd_chk(`REG_ERR_COUNT, e, "error count");
  endtask
  task state(input logic run, input logic [1:0] cause);
    chk("running", {31'h0, run}, {31'h0, running_o});
    chk("stop cause", {30'h0, cause}, {30'h0, stop_cause_indicator_o});
  endtask
  initial
  begin
    #400000;
    fails++;
    complete_run;
  end
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[r])
    begin
      start(rows[r].taps, (rows[r].sel == `PRBS_15 || rows[r].sel == `PRBS_23) ^ rows[r].pol,
        {26'h0, rows[r].pol, rows[r].sel, 2'h1});
      i_dut_source.send(60, 0, 2 * rows[r].n + 4, 1);
      repeat (10) @(posedge clk_i);
      chk("sync", 32'h1, {31'h0, sync_o});
      counts(60 - 2 * rows[r].n, 32'h1);
    end
    // bit limit, then interrupt masked, unmasked and cleared
    wb(1'b1, `REG_MAX_BITS, 32'h0000000A);
    wb(1'b1, `REG_IRQ_ENABLE, 32'h00000001);
    start(P9, 1'b0, 32'h1);
    bits(40, 0);
    state(1'b0, `CAUSE_BITS);
    counts(32'h0000000A, 32'h0);
    chk("irq set", 32'h1, {31'h0, irq_o});
    wb(1'b1, `REG_IRQ_ENABLE, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    wb(1'b1, `REG_IRQ_ENABLE, 32'h00000001);
    chk("irq unmasked", 32'h1, {31'h0, irq_o});
    wb(1'b1, `REG_IRQ_CLEAR, 32'h00000001);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    // error limit hit by a burst of six bad bits
    wb(1'b1, `REG_MAX_BITS, 32'h00001000);
    wb(1'b1, `REG_MAX_ERRORS, 32'h00000003);
    start(P9, 1'b0, 32'h1);
    i_dut_source.send(40, 0, 25, 6);
    repeat (10) @(posedge clk_i);
    state(1'b0, `CAUSE_ERRORS);
    counts(32'h0000000A, 32'h00000003);
    wb(1'b1, `REG_MAX_ERRORS, 32'h00001000);
    // restart pulse ignored while external restart is off
    start(P9, 1'b0, 32'h1);
    bits(30, 0);
    i_dut_source.restart_o <= 1'b1;
    repeat (10) @(posedge clk_i);
    i_dut_source.restart_o <= 1'b0;
    bits(30, 0);
    counts(32'h0000002A, 32'h0);
    // external restart: halt, partial flag, resync, accumulation
    start(P9, 1'b0, 32'h41);
    bits(30, 0);
    i_dut_source.restart_o <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk("halt sync", 32'h0, {31'h0, sync_o});
    wb(1'b0, `REG_IRQ_STATUS, 32'h0);
    chk("partial flag", 32'h4, rd & 32'h4);
    i_dut_source.restart_o <= 1'b0;
    bits(30, 0);
    counts(32'h00000018, 32'h0);
    // low-active gating switched on mid-run with suspension, then high-active suspension
    start(P9, 1'b0, 32'h1);
    bits(30, 0);
    wb(1'b1, `REG_CTRL, 32'h00000100);
    counts(32'h0, 32'h0);
    bits(30, 0);
    data_enable_i <= 1'b1;
    bits(20, 1);
    data_enable_i <= 1'b0;
    bits(10, 0);
    counts(32'h00000016, 32'h0);
    data_enable_i <= 1'b1;
    start(P9, 1'b0, 32'h81);
    bits(30, 0);
    data_enable_i <= 1'b0;
    bits(20, 1);
    counts(32'h0000000C, 32'h0);
    // exclusion of long runs of ones, then of zeros under inverted polarity
    start(P9, 1'b0, 32'h201);
    bits(80, 0);
    counts(32'h0000001E, 32'h0);
    bits(40, 2);
    bits(40, 0);
    rd_chk(`REG_ERR_COUNT, 32'h0, "errors after run");
    rd_chk(`REG_BIT_COUNT, 32'h00000044, "excluded run");
    start(P9, 1'b1, 32'h421);
    bits(80, 0);
    bits(40, 2);
    bits(40, 0);
    counts(32'h00000046, 32'h0);
    // user stop, then reset in mid-run and register defaults
    start(P9, 1'b0, 32'h1);
    bits(30, 0);
    wb(1'b1, `REG_CTRL, 32'h2);
    state(1'b0, `CAUSE_USER);
    start(P9, 1'b0, 32'h1);
    bits(30, 0);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    state(1'b0, `CAUSE_NONE);
    rd_chk(`REG_MAX_BITS, `MAX_BITS_RST, "max bits reset");
    rd_chk(`REG_MAX_ERRORS, `MAX_ERRORS_RST, "max errors reset");
    rd_chk(`REG_STATUS, 32'h0, "status reset");
    wb(1'b1, `REG_BIT_COUNT, 32'h00000055);
    rd_chk(`REG_BIT_COUNT, 32'h0, "read-only count");
    rd_chk(`REG_IRQ_CLEAR, 32'h0, "write-only clear");
    rd_chk(8'h3C, 32'h0, "unmapped");
    complete_run;
  end
endmodule // tb
